// ==== rtl/scg_defs.svh ====
// Purpose: Offsets, field positions, reset values and counts for the clock control block.
// Assumes: Registers are eight bits wide and sit in the low byte of a 32-bit word.
// Notes: Definitions only; included by bare name.
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCG_ADR_W 8
`define SCG_ADR_PROTECT 8'h00
`define SCG_ADR_PM2 8'h04
`define SCG_ADR_PLLC 8'h08
`define SCG_ADR_CC0 8'h0c
`define SCG_ADR_CC1 8'h10
`define SCG_ADR_ODET 8'h14
`define SCG_ADR_STATUS 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCG_PR_CLOCK 0
`define SCG_PR_MODE2 1
`define SCG_PM2_WAIT 0
`define SCG_PM2_LOCK 1
`define SCG_PM2_WDSRC 2
`define SCG_PM2_NMI 4
`define SCG_PLLC_ENABLE 7
`define SCG_CC0_WPSTOP 2
`define SCG_CC0_SUBEN 4
`define SCG_CC0_MSTOP 5
`define SCG_CC0_DIV8 6
`define SCG_CC0_SUBSEL 7
`define SCG_CC1_STOP 0
`define SCG_CC1_PLLSEL 1
`define SCG_CC1_DIVLO 6
`define SCG_CC1_DIVHI 7
`define SCG_OD_ENABLE 0
`define SCG_OD_SYSSEL 1
`define SCG_OD_FLAG 2
`define SCG_OD_MONITOR 3
`define SCG_OD_ACTION 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCG_RST_PLL_MULT 3'h1
`define SCG_RST_DIV_SEL 2'h3
`define SCG_RST_PLL_WAIT 1'b1

// ----------------------------------------------------------------
// Divider shift codes and counter width
// ----------------------------------------------------------------
`define SCG_SHIFT_W 3
`define SCG_SHIFT_DIV1 3'h0
`define SCG_SHIFT_DIV2 3'h1
`define SCG_SHIFT_DIV4 3'h2
`define SCG_SHIFT_DIV8 3'h3
`define SCG_SHIFT_DIV16 3'h4
`define SCG_DIV_CNT_W 4

`endif

// ==== rtl/scg_pkg.sv ====
// Purpose: Types shared by the clock control block.
// Assumes: Constants live in scg_defs.svh.
// Notes: Holds the state record of the top module.
package scg_pkg;

    // Source of the CPU clock.
    typedef enum logic [1:0] {
        SCG_SRC_MAIN,
        SCG_SRC_SUB,
        SCG_SRC_ONCHIP,
        SCG_SRC_PLL
    } scg_src_e;

    // Complete state of the control block.
    typedef struct packed {
        logic prot_clock;
        logic prot_mode2;
        logic pll_wait_select;
        logic clock_modification_lock;
        logic watchdog_source_select;
        logic nonmaskable_interrupt_enable;
        logic pll_enable;
        logic [2:0] pll_mult;
        logic mult_written;
        logic wait_peripheral_stop;
        logic sub_osc_enable;
        logic main_oscillator_stop;
        logic divide_by_8_select;
        logic sub_clock_select;
        logic stop_mode_bit;
        logic pll_select;
        logic [1:0] divider_select;
        logic oscillation_detect_enable;
        logic system_clock_select;
        logic detect_flag;
        logic detect_action_select;
        logic lost_q;
        logic ack;
        logic [7:0] rdata;
    } scg_state_s;

    // State of the divider.
    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } scg_div_s;

endpackage

// ==== rtl/scg_div_if.sv ====
// Purpose: Carries the division setting to the divider and its tick back.
// Assumes: One clock domain.
// Notes: The control side drives shift and run.
`timescale 1ns/100ps
interface scg_div_if;
    logic [2:0] shift;
    logic run;
    logic tick;
    modport ctrl (output shift, output run, input tick);
    modport div (input shift, input run, output tick);
endinterface

// ==== rtl/scg_div.sv ====
// Purpose: Produces the CPU clock as a one-cycle tick every 2**shift source cycles.
// Assumes: The source clock is modelled by the system clock.
// Notes: The count restarts from zero whenever run falls.
`timescale 1ns/100ps
`include "scg_defs.svh"
module scg_div #(
    parameter int CNT_W = `SCG_DIV_CNT_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Setting and tick
    scg_div_if.div dv
);
    import scg_pkg::*;

    // A shift of four needs a four-bit count.
    if (CNT_W != 4) begin : g_bad_width
        $error("scg_div supports CNT_W of 4 only");
    end

    scg_div_s s_q;
    scg_div_s s_d;
    logic [3:0] last;

    // Last count value before a tick; divide by one ticks every cycle.
    always_comb begin
        last = 4'h0;
        case (dv.shift)
            `SCG_SHIFT_DIV2: last = 4'h1;
            `SCG_SHIFT_DIV4: last = 4'h3;
            `SCG_SHIFT_DIV8: last = 4'h7;
            `SCG_SHIFT_DIV16: last = 4'hf;
            default: last = 4'h0;
        endcase
    end

    // Next count and tick.
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!dv.run) begin
            s_d.cnt = 4'h0;
        end else if (s_q.cnt >= last) begin
            s_d.cnt = 4'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    // State register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dv.tick = s_q.tick;
endmodule

// ==== rtl/scg_top.sv ====
// Purpose: Clock generation control: source select, divider, PLL gate, locks and stop mode.
// Assumes: Classic Wishbone slave with 8-bit registers in the low byte lane.
// Notes: Oscillators are controlled by enables; the CPU clock is shown as a tick.
`timescale 1ns/100ps
`include "scg_defs.svh"
module scg_top (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SCG_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // System events
    input wire logic main_clock_lost,
    input wire logic wait_mode,
    input wire logic stop_wakeup,
    // Oscillator and PLL controls
    output logic main_osc_run,
    output logic sub_osc_run,
    output logic sub_feedback_connect,
    output logic onchip_osc_run,
    output logic pll_run,
    output logic [2:0] pll_multiplier,
    output logic pll_wait_select,
    // CPU and peripheral clocking
    output scg_pkg::scg_src_e cpu_source,
    output logic cpu_clock_tick,
    output logic stop_active,
    output logic peripheral_clock_off,
    // Watchdog and interrupt settings
    output logic watchdog_onchip_source,
    output logic watchdog_run,
    output logic nonmaskable_interrupt_enable
);
    import scg_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------

    // Two stages so that reset leaves the logic on a clock edge.
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // State and bus decode
    // ----------------------------------------------------------------
    scg_state_s s_q;
    scg_state_s s_d;
    scg_src_e src;
    logic req;
    logic wr;
    logic [7:0] wd;
    logic [2:0] shift;
    logic lost_rise;
    logic go_stop;
    scg_div_if div_bus ();

    assign req = wb_cyc_i && wb_stb_i;
    // A write lands in the cycle the acknowledge is shown, while the master still holds it.
    assign wr = req && wb_we_i && s_q.ack && wb_sel_i[0];
    assign wd = wb_dat_i[7:0];
    assign lost_rise = main_clock_lost && !s_q.lost_q;

    // CPU clock source; sub select overrides, then on-chip, then PLL.
    always_comb begin
        if (s_q.sub_clock_select) begin
            src = SCG_SRC_SUB;
        end else if (s_q.system_clock_select) begin
            src = SCG_SRC_ONCHIP;
        end else if (s_q.pll_select) begin
            src = SCG_SRC_PLL;
        end else begin
            src = SCG_SRC_MAIN;
        end
    end

    // Division setting for the CPU clock.
    always_comb begin
        if (src == SCG_SRC_SUB || src == SCG_SRC_PLL) begin
            shift = `SCG_SHIFT_DIV1;
        end else if (s_q.divide_by_8_select) begin
            shift = `SCG_SHIFT_DIV8;
        end else begin
            case (s_q.divider_select)
                2'h0: shift = `SCG_SHIFT_DIV1;
                2'h1: shift = `SCG_SHIFT_DIV2;
                2'h2: shift = `SCG_SHIFT_DIV4;
                default: shift = `SCG_SHIFT_DIV16;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        go_stop = 1'b0;
        s_d.lost_q = main_clock_lost;
        // Acknowledge every request for one cycle, mapped or not.
        s_d.ack = req && !s_q.ack;
        s_d.rdata = 8'h00;

        // Read data is captured as the acknowledge rises.
        if (req && !s_q.ack && !wb_we_i) begin
            if (wb_adr_i == `SCG_ADR_PROTECT) begin
                s_d.rdata = {6'h00, s_q.prot_mode2, s_q.prot_clock};
            end else if (wb_adr_i == `SCG_ADR_PM2) begin
                s_d.rdata = {3'h0, s_q.nonmaskable_interrupt_enable, 1'b0,
                    s_q.watchdog_source_select, s_q.clock_modification_lock,
                    s_q.pll_wait_select};
            end else if (wb_adr_i == `SCG_ADR_PLLC) begin
                s_d.rdata = {s_q.pll_enable, 4'h0, s_q.pll_mult};
            end else if (wb_adr_i == `SCG_ADR_CC0) begin
                s_d.rdata = {s_q.sub_clock_select, s_q.divide_by_8_select,
                    s_q.main_oscillator_stop, s_q.sub_osc_enable, 1'b0,
                    s_q.wait_peripheral_stop, 2'h0};
            end else if (wb_adr_i == `SCG_ADR_CC1) begin
                s_d.rdata = {s_q.divider_select, 4'h0, s_q.pll_select, s_q.stop_mode_bit};
            end else if (wb_adr_i == `SCG_ADR_ODET) begin
                s_d.rdata = {s_q.detect_action_select, 3'h0, main_clock_lost,
                    s_q.detect_flag, s_q.system_clock_select,
                    s_q.oscillation_detect_enable};
            end else if (wb_adr_i == `SCG_ADR_STATUS) begin
                s_d.rdata = {1'b0, src, pll_run, onchip_osc_run, sub_osc_run,
                    main_osc_run, s_q.stop_mode_bit};
            end else begin
                s_d.rdata = 8'h00;
            end
        end

        // Register writes.
        if (wr) begin
            if (wb_adr_i == `SCG_ADR_PROTECT) begin
                s_d.prot_clock = wd[`SCG_PR_CLOCK];
                s_d.prot_mode2 = wd[`SCG_PR_MODE2];
            end else if (wb_adr_i == `SCG_ADR_PM2 && s_q.prot_mode2) begin
                // wait select only with PLL off
                if (!s_q.pll_enable) begin
                    s_d.pll_wait_select = wd[`SCG_PM2_WAIT];
                end
                s_d.clock_modification_lock = s_q.clock_modification_lock
                    | wd[`SCG_PM2_LOCK];
                s_d.watchdog_source_select = wd[`SCG_PM2_WDSRC];
                s_d.nonmaskable_interrupt_enable = s_q.nonmaskable_interrupt_enable
                    | wd[`SCG_PM2_NMI];
            end else if (wb_adr_i == `SCG_ADR_PLLC && s_q.prot_clock
                    && !s_q.clock_modification_lock) begin
                s_d.pll_enable = wd[`SCG_PLLC_ENABLE];
                if (!s_q.pll_enable && !s_q.mult_written) begin
                    s_d.pll_mult = wd[2:0];
                    s_d.mult_written = 1'b1;
                end
            end else if (wb_adr_i == `SCG_ADR_CC0 && s_q.prot_clock) begin
                s_d.sub_osc_enable = wd[`SCG_CC0_SUBEN];
                s_d.divide_by_8_select = wd[`SCG_CC0_DIV8];
                if (!s_q.clock_modification_lock) begin
                    s_d.wait_peripheral_stop = wd[`SCG_CC0_WPSTOP];
                    s_d.main_oscillator_stop = wd[`SCG_CC0_MSTOP];
                    s_d.sub_clock_select = wd[`SCG_CC0_SUBSEL];
                    if (wd[`SCG_CC0_MSTOP] && !s_q.main_oscillator_stop
                            && s_q.sub_clock_select) begin
                        s_d.divide_by_8_select = 1'b1;
                    end
                end
            end else if (wb_adr_i == `SCG_ADR_CC1 && s_q.prot_clock) begin
                s_d.divider_select = {wd[`SCG_CC1_DIVHI], wd[`SCG_CC1_DIVLO]};
                // lock freezes stop and PLL select
                if (!s_q.clock_modification_lock) begin
                    s_d.pll_select = wd[`SCG_CC1_PLLSEL];
                    if (!s_q.watchdog_source_select && wd[`SCG_CC1_STOP]) begin
                        go_stop = 1'b1;
                    end
                end
            end else if (wb_adr_i == `SCG_ADR_ODET && s_q.prot_clock) begin
                if (!s_q.clock_modification_lock) begin
                    s_d.oscillation_detect_enable = wd[`SCG_OD_ENABLE];
                end
                s_d.system_clock_select = wd[`SCG_OD_SYSSEL];
                // Only a zero clears the flag; a one has no effect.
                if (!wd[`SCG_OD_FLAG]) begin
                    s_d.detect_flag = 1'b0;
                end
                s_d.detect_action_select = wd[`SCG_OD_ACTION];
            end
        end

        if (go_stop) begin
            s_d.stop_mode_bit = 1'b1;
            if (!s_q.sub_clock_select) begin
                s_d.divide_by_8_select = 1'b1;
            end
        end else if (s_q.stop_mode_bit && stop_wakeup) begin
            s_d.stop_mode_bit = 1'b0;
        end

        // With main off and on-chip off the divide-by-8 select stays set; sub and PLL sources still divide by one.
        if (s_d.main_oscillator_stop && !s_d.system_clock_select) begin
            s_d.divide_by_8_select = 1'b1;
        end

        // Detection applies after software writes so a set is never lost.
        if (lost_rise && s_q.oscillation_detect_enable) begin
            s_d.detect_flag = 1'b1;
            if (s_q.detect_action_select && !s_q.pll_select) begin
                s_d.system_clock_select = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.pll_mult <= `SCG_RST_PLL_MULT;
            s_q.pll_wait_select <= `SCG_RST_PLL_WAIT;
            s_q.divider_select <= `SCG_RST_DIV_SEL;
            s_q.system_clock_select <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Clock divider
    // ----------------------------------------------------------------

    assign div_bus.shift = shift;
    assign div_bus.run = !s_q.stop_mode_bit;

    scg_div #(
        .CNT_W(`SCG_DIV_CNT_W)
    ) u_div (
        .clock(clock),
        .rst_n(rst_n),
        .dv(div_bus)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = {24'h000000, s_q.rdata};

    assign main_osc_run = !s_q.main_oscillator_stop && !s_q.stop_mode_bit;
    assign sub_osc_run = s_q.sub_osc_enable && !s_q.stop_mode_bit;
    assign sub_feedback_connect = sub_osc_run;
    assign onchip_osc_run = (s_q.system_clock_select || s_q.watchdog_source_select)
        && !s_q.stop_mode_bit;
    assign pll_run = s_q.pll_enable && main_osc_run;
    assign pll_multiplier = s_q.pll_mult;
    // The wait setting only matters while the PLL runs.
    assign pll_wait_select = s_q.pll_wait_select;
    assign cpu_source = src;
    assign cpu_clock_tick = div_bus.tick;
    assign stop_active = s_q.stop_mode_bit;
    assign peripheral_clock_off = s_q.stop_mode_bit
        || (wait_mode && s_q.wait_peripheral_stop);
    assign watchdog_onchip_source = s_q.watchdog_source_select;
    assign watchdog_run = !s_q.stop_mode_bit
        && (!wait_mode || s_q.watchdog_source_select);
    assign nonmaskable_interrupt_enable = s_q.nonmaskable_interrupt_enable;
endmodule

// ==== test/scg_assertions.sv ====
// Purpose: Concurrent checks on the clock control block's ports.
// Assumes: One clock domain; nrst disables every check.
// Notes: Bound to scg_top below the module.
`timescale 1ns/100ps
module scg_assertions
    import scg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Bus and events
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wait_mode,
    // Clock controls
    input wire logic main_osc_run,
    input wire logic sub_osc_run,
    input wire logic onchip_osc_run,
    input wire logic pll_run,
    input wire scg_src_e cpu_source,
    input wire logic stop_active,
    input wire logic watchdog_onchip_source,
    input wire logic watchdog_run,
    input wire logic nonmaskable_interrupt_enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // Each taken request is answered next cycle with a single pulse.
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one-cycle answer");
    nmi_sticky_a: assert property (
        nonmaskable_interrupt_enable |=> nonmaskable_interrupt_enable)
        else $error("nmi enable fell");
    wd_osc_a: assert property (watchdog_onchip_source |-> onchip_osc_run)
        else $error("onchip osc off with watchdog source");
    stop_clocks_a: assert property (stop_active |-> !main_osc_run && !sub_osc_run
        && !onchip_osc_run && !pll_run) else $error("clock running in stop");
    wd_wait_a: assert property (wait_mode && watchdog_onchip_source && !stop_active
        |-> watchdog_run) else $error("watchdog halted in wait");
    wd_stop_a: assert property (watchdog_onchip_source && !stop_active |=> !stop_active)
        else $error("stop entered with watchdog source");
    // on-chip source runs; stop mode halts it legally.
    onchip_src_a: assert property (
        cpu_source == SCG_SRC_ONCHIP && !stop_active |-> onchip_osc_run)
        else $error("onchip source without oscillator");
    pll_src_a: assert property (cpu_source == SCG_SRC_PLL |-> pll_run)
        else $error("pll source without pll");
endmodule

bind scg_top scg_assertions u_scg_assertions (
    .clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wait_mode(wait_mode), .main_osc_run(main_osc_run),
    .sub_osc_run(sub_osc_run), .onchip_osc_run(onchip_osc_run), .pll_run(pll_run),
    .cpu_source(cpu_source), .stop_active(stop_active),
    .watchdog_onchip_source(watchdog_onchip_source), .watchdog_run(watchdog_run),
    .nonmaskable_interrupt_enable(nonmaskable_interrupt_enable)
);

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the clock control block.
// Assumes: Wishbone ack comes one cycle after the request is taken.
// Notes: Each scenario starts from a fresh reset.
`timescale 1ns/100ps
`include "scg_defs.svh"
module testbench;
    import scg_pkg::*;
    logic clock, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, main_clock_lost, wait_mode;
    logic stop_wakeup, main_osc_run, sub_osc_run, sub_feedback_connect, onchip_osc_run;
    logic pll_run, pll_wait_select, cpu_clock_tick, stop_active, peripheral_clock_off;
    logic watchdog_onchip_source, watchdog_run, nonmaskable_interrupt_enable;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i;
    logic [2:0] pll_multiplier;
    scg_src_e cpu_source;
    int errors = 0, checked = 0, n;

    scg_top u_scg_top (
        .clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .main_clock_lost(main_clock_lost),
        .wait_mode(wait_mode), .stop_wakeup(stop_wakeup), .main_osc_run(main_osc_run),
        .sub_osc_run(sub_osc_run), .sub_feedback_connect(sub_feedback_connect),
        .onchip_osc_run(onchip_osc_run), .pll_run(pll_run), .pll_multiplier(pll_multiplier),
        .pll_wait_select(pll_wait_select), .cpu_source(cpu_source),
        .cpu_clock_tick(cpu_clock_tick), .stop_active(stop_active),
        .peripheral_clock_off(peripheral_clock_off),
        .watchdog_onchip_source(watchdog_onchip_source), .watchdog_run(watchdog_run),
        .nonmaskable_interrupt_enable(nonmaskable_interrupt_enable)
    );

    // ----------------------------------------------------------------
    // Clock, bus tasks and compare
    // ----------------------------------------------------------------
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One classic cycle; read data is taken at the ack edge only.
    task automatic bus(logic we, logic [7:0] a, logic [7:0] d);
        int i;
        @(posedge clock);
        wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= {24'h0, d};
        i = 0;
        do begin @(posedge clock); i++; end while (wb_ack_o !== 1'b1 && i < 20);
        chk("ack", 1, i < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 0; wb_stb_i <= 0;
        // The write lands at the ack edge; one more edge makes it visible to the caller.
        @(posedge clock);
    endtask

    // Cycles between two ticks, taken after one period has settled.
    task automatic per();
        int i;
        repeat (2) begin
            i = 0;
            while (cpu_clock_tick !== 1'b1 && i < 40) begin @(posedge clock); i++; end
            n = 0;
            do begin @(posedge clock); n++; end while (cpu_clock_tick !== 1'b1 && n < 40);
        end
    endtask

    task automatic rst();
        nrst <= 0; wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0; wb_adr_i <= 8'h00;
        wb_dat_i <= 32'h0; wb_sel_i <= 4'h1; main_clock_lost <= 0; wait_mode <= 0;
        stop_wakeup <= 0;
        repeat (2) @(posedge clock);
        nrst <= 1;
        repeat (3) @(posedge clock);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        int ex[4] = '{1, 2, 4, 16};
        rst();
        chk("sub_run", 0, {sub_osc_run, sub_feedback_connect});
        chk("onchip", 1, onchip_osc_run);
        chk("src", SCG_SRC_ONCHIP, cpu_source);
        chk("pll", 0, pll_run);
        per();
        chk("div16", 16, n);
        bus(1, `SCG_ADR_PROTECT, 8'h01);
        for (int k = 0; k < 4; k++) begin
            bus(1, `SCG_ADR_CC1, 8'(k << 6));
            per();
            chk("div", ex[k], n);
        end
        bus(1, `SCG_ADR_CC0, 8'h40);
        per();
        chk("div8", 8, n);
    endtask

    task automatic t_prot();
        rst();
        bus(1, `SCG_ADR_PROTECT, 8'h01);
        bus(1, `SCG_ADR_PM2, 8'h10);
        chk("nmi_unprot", 0, nonmaskable_interrupt_enable);
        bus(1, `SCG_ADR_PROTECT, 8'h03);
        bus(1, `SCG_ADR_PM2, 8'h12);
        bus(1, `SCG_ADR_PM2, 8'h00);
        bus(0, `SCG_ADR_PM2, 8'h00);
        chk("lock", 1, rd[`SCG_PM2_LOCK]);
        chk("nmi", 1, nonmaskable_interrupt_enable);
        bus(1, `SCG_ADR_CC1, 8'h01);
        bus(1, `SCG_ADR_PLLC, 8'h80);
        chk("locked", 0, {stop_active, pll_run});
    endtask

    task automatic t_wd();
        rst();
        bus(1, `SCG_ADR_PROTECT, 8'h03);
        bus(1, `SCG_ADR_PM2, 8'h04);
        bus(1, `SCG_ADR_ODET, 8'h00);
        chk("wd_osc", 1, onchip_osc_run);
        chk("src_main", SCG_SRC_MAIN, cpu_source);
        bus(1, `SCG_ADR_CC1, 8'h01);
        chk("wd_stop", 0, stop_active);
        wait_mode <= 1;
        @(posedge clock);
        @(negedge clock);
        chk("wd_wait", 1, watchdog_run);
    endtask

    task automatic t_stop();
        rst();
        bus(1, `SCG_ADR_PROTECT, 8'h01);
        bus(1, `SCG_ADR_ODET, 8'h00);
        chk("osc_off", 0, onchip_osc_run);
        bus(1, `SCG_ADR_CC1, 8'h01);
        chk("stop", 1, stop_active);
        chk("clocks", 0, {main_osc_run, onchip_osc_run, sub_osc_run});
        chk("periph_off", 1, peripheral_clock_off);
        bus(0, `SCG_ADR_CC0, 8'h00);
        chk("div8_set", 1, rd[`SCG_CC0_DIV8]);
        stop_wakeup <= 1;
        @(posedge clock);
        stop_wakeup <= 0;
        repeat (2) @(posedge clock);
        chk("wake", 0, stop_active);
    endtask

    task automatic t_pll();
        rst();
        bus(1, `SCG_ADR_PROTECT, 8'h03);
        bus(1, `SCG_ADR_ODET, 8'h00);
        bus(1, `SCG_ADR_PM2, 8'h00);
        chk("pll_wait", 0, pll_wait_select);
        bus(1, `SCG_ADR_CC0, 8'h00);
        bus(1, `SCG_ADR_CC1, 8'h00);
        bus(1, `SCG_ADR_PLLC, 8'h02);
        chk("pll_off", 0, pll_run);
        bus(1, `SCG_ADR_PLLC, 8'h81);
        chk("mult", 3'h2, pll_multiplier);
        chk("pll_on", 1, pll_run);
        bus(1, `SCG_ADR_PM2, 8'h01);
        chk("wait_held", 0, pll_wait_select);
        repeat (20) @(posedge clock);
        bus(1, `SCG_ADR_CC1, 8'h02);
        chk("src_pll", SCG_SRC_PLL, cpu_source);
        per();
        chk("pll_div1", 1, n);
        bus(1, `SCG_ADR_CC1, 8'h00);
        bus(1, `SCG_ADR_PLLC, 8'h00);
        chk("pll_stop", 0, {pll_run, cpu_source});
    endtask

    task automatic t_fall();
        rst();
        bus(1, `SCG_ADR_PROTECT, 8'h01);
        bus(1, `SCG_ADR_ODET, 8'h81);
        main_clock_lost <= 1;
        repeat (3) @(posedge clock);
        chk("fallback", 1, onchip_osc_run);
        chk("fb_src", SCG_SRC_ONCHIP, cpu_source);
    endtask

    // ----------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        rst();
        t_reset();
        t_prot();
        t_wd();
        t_stop();
        t_pll();
        t_fall();
        end_sim();
    end

    // The whole run needs well under 2000 cycles.
    initial begin
        #100000;
        errors++;
        end_sim();
    end
endmodule
